// File: core/vic_top.sv
`default_nettype none
module vic_top (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // register bus
  input  wire vic_pkg::vic_axi_req_t axi_req,
  output var vic_pkg::vic_axi_rsp_t  axi_rsp,
  // pins and peripheral events
  input  wire logic                  ext_irq_pin,
  input  wire logic                  timer_clk_pin,
  input  wire vic_pkg::vic_evt_t     evt,
  // core side
  input  wire logic                  instr_boundary,
  input  wire logic                  return_from_irq_instr,
  input  wire logic [15:0]           return_pc,
  output logic                       vec_load,
  output logic [15:0]                vec_addr,
  output logic [15:0]                push_pc,
  output logic                       wake_req,
  output logic                       global_irq_disable
);
  import vic_pkg::*;

  typedef struct packed {
    logic        glint;
    logic [3:0]  en;
    logic        ext_f;
    logic        t0_f;
    logic        tclk_f;
    logic        ext_sel;
    logic        tclk_sel;
    logic        ssp_f;
    logic        bcl_f;
    logic        adc_f;
    logic        cap4_f;
    logic        cap3_f;
    logic [7:0]  pie2;
    logic        aw_h;
    logic [7:0]  aw_a;
    logic        w_h;
    logic [7:0]  w_d;
    logic        w_s;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [15:0] rdata;
    logic [1:0]  rresp;
    logic        vec_load;
    logic [15:0] vec_addr;
    logic [15:0] push_pc;
    logic        wake;
  } vic_state_t;

  vic_state_t  st_ff;
  vic_state_t  nxt_st;
  logic        ext_edge;
  logic        tclk_edge;
  logic [1:0]  pin_vec;
  logic [1:0]  sel_vec;
  logic [1:0]  edge_vec;
  logic [7:0]  csr_v;
  logic [7:0]  ise_v;
  logic [7:0]  tsr_v;
  logic [7:0]  pf2_v;
  logic        periph_summary_flag;
  logic        req_ext;
  logic        req_t0;
  logic        req_tclk;
  logic        req_per;
  logic        take;
  logic [15:0] take_vec;
  logic        aw_fire;
  logic        w_fire;
  logic        ar_fire;
  logic [7:0]  wr_a;
  logic [7:0]  wr_d;
  logic        wr_s;
  logic        wr_go;
  logic        wr_ok;
  logic        rd_ok;
  logic [15:0] rd_v;

  // one edge detector per external pin
  assign pin_vec = {timer_clk_pin, ext_irq_pin};
  assign sel_vec = {st_ff.tclk_sel, st_ff.ext_sel};
  for (genvar i = 0; i < 2; i++) begin : g_edge
    vic_edge u_edge (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .pin        (pin_vec[i]),
      .rise_sel   (sel_vec[i]),
      .edge_pulse (edge_vec[i])
    );
  end
  assign ext_edge  = edge_vec[0];
  assign tclk_edge = edge_vec[1];

  // register views as software sees them
  always_comb begin
    csr_v                = 8'h00;
    csr_v[GLINT_BIT]     = st_ff.glint;
    tsr_v                = 8'h00;
    tsr_v[EXT_EDGE_BIT]  = st_ff.ext_sel;
    tsr_v[TCLK_EDGE_BIT] = st_ff.tclk_sel;
    pf2_v                = 8'h00; // unused bit stays zero
    pf2_v[SSP_BIT]       = st_ff.ssp_f;
    pf2_v[BCL_BIT]       = st_ff.bcl_f;
    pf2_v[ADC_BIT]       = st_ff.adc_f;
    pf2_v[CAP4_BIT]      = st_ff.cap4_f;
    pf2_v[CAP3_BIT]      = st_ff.cap3_f;
    pf2_v[TX2_BIT]       = evt.serial2_tx_empty;
    pf2_v[RX2_BIT]       = evt.serial2_rx_full;
    periph_summary_flag                 = |(pf2_v & st_ff.pie2);
    ise_v                = {4'h0, st_ff.en};
    ise_v[EXT_F_BIT]     = st_ff.ext_f;
    ise_v[T0_F_BIT]      = st_ff.t0_f;
    ise_v[TCLK_F_BIT]    = st_ff.tclk_f;
    ise_v[SUM_F_BIT]     = periph_summary_flag;
  end

  // gated requests and fixed priority
  always_comb begin
    req_ext  = st_ff.ext_f && st_ff.en[EXT_EN_BIT];
    req_t0   = st_ff.t0_f && st_ff.en[T0_EN_BIT];
    req_tclk = st_ff.tclk_f && st_ff.en[TCLK_EN_BIT];
    req_per  = periph_summary_flag && st_ff.en[GRP_EN_BIT];
    take     = instr_boundary && !st_ff.glint &&
               (req_ext || req_t0 || req_tclk || req_per);
    if (req_ext) begin
      take_vec = VEC_EXT;
    end else if (req_t0) begin
      take_vec = VEC_T0;
    end else if (req_tclk) begin
      take_vec = VEC_TCLK;
    end else begin
      take_vec = VEC_PER;
    end
  end

  // bus handshakes and decode
  always_comb begin
    aw_fire = axi_req.awvalid && axi_rsp.awready;
    w_fire  = axi_req.wvalid && axi_rsp.wready;
    ar_fire = axi_req.arvalid && axi_rsp.arready;
    wr_a    = st_ff.aw_h ? st_ff.aw_a : axi_req.awaddr;
    wr_d    = st_ff.w_h ? st_ff.w_d : axi_req.wdata[7:0];
    wr_s    = st_ff.w_h ? st_ff.w_s : axi_req.wstrb[0];
    wr_go   = (st_ff.aw_h || aw_fire) && (st_ff.w_h || w_fire);
    wr_ok   = (wr_a == CSR_OFS) || (wr_a == ISE_OFS) || (wr_a == TSR_OFS) ||
              (wr_a == PF2_OFS) || (wr_a == PE2_OFS) || (wr_a == VEC_OFS);
    rd_ok   = 1'b1;
    case (axi_req.araddr)
      CSR_OFS: rd_v = {8'h00, csr_v};
      ISE_OFS: rd_v = {8'h00, ise_v};
      TSR_OFS: rd_v = {8'h00, tsr_v};
      PF2_OFS: rd_v = {8'h00, pf2_v};
      PE2_OFS: rd_v = {8'h00, st_ff.pie2};
      VEC_OFS: rd_v = st_ff.vec_addr;
      default: begin
        rd_v  = 16'h0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.vec_load = 1'b0;
    // write address and data may arrive in either order
    if (aw_fire) begin
      nxt_st.aw_h = 1'b1;
      nxt_st.aw_a = axi_req.awaddr;
    end
    if (w_fire) begin
      nxt_st.w_h = 1'b1;
      nxt_st.w_d = axi_req.wdata[7:0];
      nxt_st.w_s = axi_req.wstrb[0];
    end
    if (st_ff.bvalid && axi_req.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_h   = 1'b0;
      nxt_st.w_h    = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // software writes; low byte lane only
    if (wr_go && wr_s) begin
      case (wr_a)
        CSR_OFS: nxt_st.glint = wr_d[GLINT_BIT];
        ISE_OFS: begin
          nxt_st.en     = wr_d[3:0];
          nxt_st.ext_f  = wr_d[EXT_F_BIT];
          nxt_st.t0_f   = wr_d[T0_F_BIT];
          nxt_st.tclk_f = wr_d[TCLK_F_BIT];
        end
        TSR_OFS: begin
          nxt_st.ext_sel  = wr_d[EXT_EDGE_BIT];
          nxt_st.tclk_sel = wr_d[TCLK_EDGE_BIT];
        end
        PF2_OFS: begin
          nxt_st.ssp_f  = wr_d[SSP_BIT];
          nxt_st.bcl_f  = wr_d[BCL_BIT];
          nxt_st.adc_f  = wr_d[ADC_BIT];
          nxt_st.cap4_f = wr_d[CAP4_BIT];
          nxt_st.cap3_f = wr_d[CAP3_BIT];
        end
        PE2_OFS: nxt_st.pie2 = wr_d;
        default: nxt_st.pie2 = st_ff.pie2;
      endcase
    end
    // read channel: one read at a time
    if (st_ff.rvalid && axi_req.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_v;
      nxt_st.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // hardware sets win over a software clear in the same cycle
    if (ext_edge) nxt_st.ext_f = 1'b1;
    if (evt.t0_overflow) nxt_st.t0_f = 1'b1;
    if (tclk_edge) nxt_st.tclk_f = 1'b1;
    if (evt.ssp_event) nxt_st.ssp_f = 1'b1;
    if (evt.bus_collision) nxt_st.bcl_f = 1'b1;
    if (evt.conv_done) nxt_st.adc_f = 1'b1;
    if (evt.capture_four) nxt_st.cap4_f = 1'b1;
    if (evt.capture_three) nxt_st.cap3_f = 1'b1;
    // return re-enables, then entry disables again
    if (return_from_irq_instr) nxt_st.glint = 1'b0;
    if (take) begin
      nxt_st.glint    = 1'b1;
      nxt_st.vec_load = 1'b1;
      nxt_st.vec_addr = take_vec;
      nxt_st.push_pc  = return_pc;
    end
    // wake request ignores the global disable bit
    nxt_st.wake = (nxt_st.ext_f && nxt_st.en[EXT_EN_BIT]) ||
                  (nxt_st.tclk_f && nxt_st.en[TCLK_EN_BIT]);
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff          <= '0;
      st_ff.glint    <= CSR_RST[GLINT_BIT];
      st_ff.en       <= ISE_RST[3:0];
      st_ff.ext_sel  <= TSR_RST[EXT_EDGE_BIT];
      st_ff.tclk_sel <= TSR_RST[TCLK_EDGE_BIT];
      st_ff.adc_f    <= PF2_RST[ADC_BIT];
      st_ff.pie2     <= PE2_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs
  always_comb begin
    axi_rsp.awready = !st_ff.aw_h && !st_ff.bvalid;
    axi_rsp.wready  = !st_ff.w_h && !st_ff.bvalid;
    axi_rsp.bvalid  = st_ff.bvalid;
    axi_rsp.bresp   = st_ff.bresp;
    axi_rsp.arready = !st_ff.rvalid;
    axi_rsp.rvalid  = st_ff.rvalid;
    axi_rsp.rdata   = {16'h0000, st_ff.rdata};
    axi_rsp.rresp   = st_ff.rresp;
  end
  assign vec_load           = st_ff.vec_load;
  assign vec_addr           = st_ff.vec_addr;
  assign push_pc            = st_ff.push_pc;
  assign wake_req           = st_ff.wake;
  assign global_irq_disable = st_ff.glint;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_disable_a: assert property ($rose(aresetn) |-> global_irq_disable)
    else $error("global disable clear after reset");

  entry_disable_a: assert property (vec_load |-> global_irq_disable &&
    push_pc == $past(return_pc))
    else $error("vector entry did not disable or push");

  entry_gate_a: assert property (vec_load |-> $past(instr_boundary) &&
    !$past(st_ff.glint))
    else $error("vector taken while blocked or off boundary");

  prio_ext_a: assert property (vec_load && $past(req_ext) |-> vec_addr == VEC_EXT)
    else $error("external pin request not vectored first");

  per_vector_a: assert property (vec_load && vec_addr == VEC_PER |->
    $past(st_ff.en[GRP_EN_BIT]) && !$past(req_ext) && !$past(req_t0) && !$past(req_tclk))
    else $error("peripheral vector without group enable or with higher request");

  return_enable_a: assert property ($past(return_from_irq_instr) && !vec_load &&
    !($past(wr_go) && $past(wr_s) && $past(wr_a) == CSR_OFS) |-> !global_irq_disable)
    else $error("return did not clear global disable");

  flag_set_a: assert property (ext_edge ##1 1'b1 |-> st_ff.ext_f)
    else $error("external pin flag lost its edge");

  conv_flag_a: assert property (evt.conv_done |=> st_ff.adc_f [*1] ##0 pf2_v[ADC_BIT])
    else $error("converter flag not set by conversion end");

  wake_level_a: assert property (st_ff.tclk_f && st_ff.en[TCLK_EN_BIT] ##1
    st_ff.tclk_f && st_ff.en[TCLK_EN_BIT] |-> wake_req)
    else $error("timer pin request did not raise wake");

  // helper: a read of the flag register is being answered
  logic rvalid_pf2;
  logic rd_pf2_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pf2_ff <= 1'b0;
    end else if (ar_fire) begin
      rd_pf2_ff <= (axi_req.araddr == PF2_OFS);
    end
  end
  assign rvalid_pf2 = st_ff.rvalid && rd_pf2_ff;

  unused_zero_a: assert property (rvalid_pf2 |-> axi_rsp.rdata[NONE_BIT] == 1'b0)
    else $error("unimplemented flag bit read as one");
endmodule
`default_nettype wire

// File: inc/vic_pkg.sv
`default_nettype none
package vic_pkg;
  // register byte offsets
  localparam logic [7:0] CSR_OFS = 8'h00;
  localparam logic [7:0] ISE_OFS = 8'h04;
  localparam logic [7:0] TSR_OFS = 8'h08;
  localparam logic [7:0] PF2_OFS = 8'h0c;
  localparam logic [7:0] PE2_OFS = 8'h10;
  localparam logic [7:0] VEC_OFS = 8'h14;
  // reset values
  localparam logic [7:0] CSR_RST = 8'h10;
  localparam logic [7:0] ISE_RST = 8'h00;
  localparam logic [7:0] TSR_RST = 8'h00;
  localparam logic [7:0] PF2_RST = 8'h00;
  localparam logic [7:0] PE2_RST = 8'h00;
  // core status field
  localparam int GLINT_BIT = 4;
  // irq status and enable fields
  localparam int EXT_EN_BIT   = 0;
  localparam int T0_EN_BIT    = 1;
  localparam int TCLK_EN_BIT  = 2;
  localparam int GRP_EN_BIT   = 3;
  localparam int EXT_F_BIT    = 4;
  localparam int T0_F_BIT     = 5;
  localparam int TCLK_F_BIT   = 6;
  localparam int SUM_F_BIT    = 7;
  // timer zero status fields
  localparam int EXT_EDGE_BIT  = 7;
  localparam int TCLK_EDGE_BIT = 6;
  // peripheral flag 2 fields
  localparam int SSP_BIT  = 7;
  localparam int BCL_BIT  = 6;
  localparam int ADC_BIT  = 5;
  localparam int NONE_BIT = 4;
  localparam int CAP4_BIT = 3;
  localparam int CAP3_BIT = 2;
  localparam int TX2_BIT  = 1;
  localparam int RX2_BIT  = 0;
  // fixed vectors
  localparam logic [15:0] VEC_EXT  = 16'h0008;
  localparam logic [15:0] VEC_T0   = 16'h0010;
  localparam logic [15:0] VEC_TCLK = 16'h0018;
  localparam logic [15:0] VEC_PER  = 16'h0020;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // bus master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } vic_axi_req_t;
  // slave to bus master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } vic_axi_rsp_t;
  // peripheral event pulses and hardware levels
  typedef struct packed {
    logic t0_overflow;
    logic capture_four;
    logic capture_three;
    logic conv_done;
    logic bus_collision;
    logic ssp_event;
    logic serial2_tx_empty;
    logic serial2_rx_full;
  } vic_evt_t;
endpackage
`default_nettype wire

// File: core/vic_edge.sv
`default_nettype none
module vic_edge (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // pin and polarity
  input  wire logic pin,
  input  wire logic rise_sel,
  // detected edge
  output logic      edge_pulse
);
  import vic_pkg::*;

  typedef struct packed {
    logic armed;
    logic prev;
    logic pulse;
  } vic_edge_st_t;

  vic_edge_st_t st_ff;
  vic_edge_st_t nxt_st;

  // edge of the chosen polarity; armed skips the first sample after reset
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.armed = 1'b1;
    nxt_st.prev  = pin;
    nxt_st.pulse = st_ff.armed && (st_ff.prev != pin) && (pin == rise_sel);
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign edge_pulse = st_ff.pulse;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  edge_polarity_a: assert property (
    edge_pulse |-> ($past(pin) == $past(rise_sel)) && ($past(pin, 2) != $past(pin)))
    else $error("edge pulse without a valid pin edge");
endmodule
`default_nettype wire

// File: dv/vic_core_model.sv
`default_nettype none
module vic_core_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // bench control
  input  wire logic        boundary_en,
  input  wire logic        ret_cmd,
  // design side
  input  wire logic        vec_load,
  input  wire logic [15:0] vec_addr,
  input  wire logic [15:0] push_pc,
  output logic             instr_boundary,
  output logic             return_from_irq_instr,
  output logic [15:0]      return_pc,
  // state seen by the bench
  output logic [15:0]      pc,
  output logic [3:0]       depth
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stack [16];
  // pc only moves on vector load or return, so the bench knows every push
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= 16'h1234;
      depth <= 4'h0;
      instr_boundary <= 1'b0;
      return_from_irq_instr <= 1'b0;
    end else begin
      instr_boundary <= boundary_en;
      return_from_irq_instr <= ret_cmd && depth != 4'h0;
      if (vec_load) begin
        stack[depth] <= push_pc;
        depth <= depth + 4'h1;
        pc <= vec_addr;
      end else if (ret_cmd && depth != 4'h0) begin
        pc <= stack[depth - 4'h1];
        depth <= depth - 4'h1;
      end
    end
  end
  // address handed over at the take edge
  assign return_pc = pc;
endmodule
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  logic         aclk = 1'b0;
  logic         aresetn;
  vic_axi_req_t req;
  vic_axi_rsp_t rsp;
  logic         ext_pin;
  logic         tclk_pin;
  vic_evt_t     evt;
  logic         boundary_en;
  logic         ret_cmd;
  logic         instr_boundary;
  logic         ret_pulse;
  logic [15:0]  return_pc;
  logic         vec_load;
  logic [15:0]  vec_addr;
  logic [15:0]  push_pc;
  logic         wake_req;
  logic         glint;
  logic [15:0]  pc;
  logic [3:0]   depth;
  int           miscompares;
  int           compares;
  int           cycles = 0;
  logic [7:0]   ise_tab [4] = '{8'h7f, 8'h6f, 8'h4f, 8'h0f};
  logic [15:0]  vec_tab [4] = '{VEC_EXT, VEC_T0, VEC_TCLK, VEC_PER};

  vic_top uut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .ext_irq_pin(ext_pin), .timer_clk_pin(tclk_pin), .evt(evt),
    .instr_boundary(instr_boundary), .return_from_irq_instr(ret_pulse),
    .return_pc(return_pc), .vec_load(vec_load), .vec_addr(vec_addr),
    .push_pc(push_pc), .wake_req(wake_req), .global_irq_disable(glint));
  vic_core_model core_m (.aclk(aclk), .aresetn(aresetn), .boundary_en(boundary_en),
    .ret_cmd(ret_cmd), .vec_load(vec_load), .vec_addr(vec_addr), .push_pc(push_pc),
    .instr_boundary(instr_boundary), .return_from_irq_instr(ret_pulse),
    .return_pc(return_pc), .pc(pc), .depth(depth));

  // clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // write with both channels offered together, held until each ready
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) break;
    end
    req.bready <= 1'b0;
    chk("bresp", er, rsp.bresp);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) break;
    end
    req.rready <= 1'b0;
    chk("rdata", ed, rsp.rdata);
    chk("rresp", er, rsp.rresp);
  endtask

  task automatic pulse(input vic_evt_t m);
    @(posedge aclk);
    evt <= evt | m;
    @(posedge aclk);
    evt <= evt & ~m;
  endtask

  task automatic no_entry();
    repeat (6) @(posedge aclk);
    chk("depth", 32'h0, depth);
  endtask

  // vector load seen within a bounded wait
  task automatic wait_entry(input logic [15:0] ev);
    int n;
    for (n = 0; n < 20 && vec_load !== 1'b1; n++) @(posedge aclk);
    chk("vec_load", 32'h1, vec_load);
    chk("vec_addr", ev, vec_addr);
    chk("push_pc", 32'h1234, push_pc);
    chk("glint", 32'h1, glint);
  endtask

  task automatic t_reset();
    chk("glint", 32'h1, glint);
    axi_rd(CSR_OFS, 32'h10, RESP_OKAY);
    axi_rd(ISE_OFS, 32'h0, RESP_OKAY);
    axi_rd(TSR_OFS, 32'h0, RESP_OKAY);
    axi_rd(PF2_OFS, 32'h0, RESP_OKAY);
    axi_rd(PE2_OFS, 32'h0, RESP_OKAY);
    axi_rd(VEC_OFS, 32'h0, RESP_OKAY);
    axi_rd(8'h40, 32'h0, RESP_SLVERR);
    axi_wr(8'h40, 32'hff, RESP_SLVERR);
    $display("done reset");
  endtask

  task automatic t_flags();
    evt.serial2_tx_empty <= 1'b1;
    pulse('{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0});
    axi_rd(PF2_OFS, 32'hee, RESP_OKAY);
    axi_rd(ISE_OFS, 32'h20, RESP_OKAY);
    evt.serial2_tx_empty <= 1'b0;
    evt.serial2_rx_full <= 1'b1;
    axi_wr(PF2_OFS, 32'hff, RESP_OKAY);
    axi_rd(PF2_OFS, 32'hed, RESP_OKAY);
    axi_wr(PF2_OFS, 32'h0, RESP_OKAY);
    axi_wr(ISE_OFS, 32'h0, RESP_OKAY);
    axi_rd(PF2_OFS, 32'h01, RESP_OKAY);
    evt.serial2_rx_full <= 1'b0;
    $display("done flags");
  endtask

  task automatic t_edges();
    logic s;
    logic [7:0] f;
    for (int i = 0; i < 4; i++) begin
      s = i[0];
      f = (i < 2) ? 8'h10 : 8'h40;
      ext_pin <= s;
      tclk_pin <= s;
      axi_wr(TSR_OFS, {24'h0, s, s, 6'h0}, RESP_OKAY);
      axi_wr(ISE_OFS, 32'h0, RESP_OKAY);
      if (i < 2) ext_pin <= !s; else tclk_pin <= !s;
      repeat (3) @(posedge aclk);
      axi_rd(ISE_OFS, 32'h0, RESP_OKAY);
      if (i < 2) ext_pin <= s; else tclk_pin <= s;
      repeat (3) @(posedge aclk);
      axi_rd(ISE_OFS, f, RESP_OKAY);
      chk("wake_off", 32'h0, wake_req);
      axi_wr(ISE_OFS, f | (f >> 4), RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("wake_on", 32'h1, wake_req);
      axi_wr(ISE_OFS, 32'h0, RESP_OKAY);
    end
    $display("done edges");
  endtask

  task automatic t_vectors();
    boundary_en <= 1'b0;
    axi_wr(PF2_OFS, 32'h08, RESP_OKAY);
    axi_wr(PE2_OFS, 32'h08, RESP_OKAY);
    axi_wr(ISE_OFS, ise_tab[0], RESP_OKAY);
    axi_wr(CSR_OFS, 32'h0, RESP_OKAY);
    no_entry();
    boundary_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i > 0) begin
        axi_wr(ISE_OFS, ise_tab[i], RESP_OKAY);
        ret_cmd <= 1'b1;
        @(posedge aclk);
        ret_cmd <= 1'b0;
      end
      wait_entry(vec_tab[i]);
    end
    axi_rd(ISE_OFS, 32'h8f, RESP_OKAY);
    axi_rd(VEC_OFS, 32'h20, RESP_OKAY);
    axi_wr(PF2_OFS, 32'h0, RESP_OKAY);
    axi_rd(ISE_OFS, 32'h0f, RESP_OKAY);
    ret_cmd <= 1'b1;
    @(posedge aclk);
    ret_cmd <= 1'b0;
    no_entry();
    chk("glint", 32'h0, glint);
    chk("pc", 32'h1234, pc);
    axi_wr(CSR_OFS, 32'h10, RESP_OKAY);
    axi_wr(ISE_OFS, 32'h0, RESP_OKAY);
    $display("done vectors");
  endtask

  task automatic t_masks();
    axi_wr(PF2_OFS, 32'h08, RESP_OKAY);
    axi_wr(CSR_OFS, 32'h0, RESP_OKAY);
    no_entry();
    axi_rd(ISE_OFS, 32'h80, RESP_OKAY);
    axi_wr(CSR_OFS, 32'h10, RESP_OKAY);
    axi_wr(PE2_OFS, 32'h0, RESP_OKAY);
    axi_wr(ISE_OFS, 32'h78, RESP_OKAY);
    axi_wr(CSR_OFS, 32'h0, RESP_OKAY);
    no_entry();
    axi_rd(ISE_OFS, 32'h78, RESP_OKAY);
    axi_wr(CSR_OFS, 32'h10, RESP_OKAY);
    axi_wr(PE2_OFS, 32'h08, RESP_OKAY);
    axi_wr(ISE_OFS, 32'h7f, RESP_OKAY);
    no_entry();
    axi_wr(ISE_OFS, 32'h0, RESP_OKAY);
    axi_wr(PF2_OFS, 32'h0, RESP_OKAY);
    axi_wr(PE2_OFS, 32'h0, RESP_OKAY);
    $display("done masks");
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    aresetn = 1'b0;
    req = '0;
    ext_pin = 1'b0;
    tclk_pin = 1'b0;
    evt = '0;
    boundary_en = 1'b0;
    ret_cmd = 1'b0;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_flags();
    t_edges();
    t_vectors();
    t_masks();
    finish_test();
  end
endmodule
`default_nettype wire
